// file: halfword_signed_transfer_decode_test.sv
// self-checking bench for the halfword/signed transfer decoder over apb
// assumes: hsd_top apb slave; memory model supplies raw load data
`timescale 1ns/1ns
`default_nettype none
module halfword_signed_transfer_decode_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] mem_addr = 32'h0000_0000;
  logic [31:0] mem_data;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int cmp_count = 0;

  always #25 pclk = ~pclk;

  hsd_top hsd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  hsd_mem_model hsd_mem_model_inst (.addr(mem_addr), .data(mem_data));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one idle cycle before each setup keeps drives one per time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      give_verdict();
    end
  endtask

  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    {n, z, cy, v} = f;
    case (c)
      4'h0: return z;
      4'h1: return !z;
      4'h2: return cy;
      4'h3: return !cy;
      4'h4: return n;
      4'h5: return !n;
      4'h6: return v;
      4'h7: return !v;
      4'h8: return cy & !z;
      4'h9: return !cy | z;
      4'ha: return n == v;
      4'hb: return n != v;
      4'hc: return !z & (n == v);
      4'hd: return z | (n != v);
      default: return 1'b1;
    endcase
  endfunction

  function automatic void expect_dec(input logic [31:0] i, input logic [3:0] f,
      input logic [31:0] b, input logic [31:0] o, input logic [31:0] ld,
      output logic [31:0] st, output logic [31:0] ad, output logic [31:0] wb,
      output logic [31:0] lr);
    logic cls, cp, und, ex, wbe;
    logic [31:0] off, md;
    cls = i[27:25] == 3'b000 && i[7] && i[4];
    cp = cond_ok(i[31:28], f);
    und = cls && i[6:5] != 2'b00 && ((!i[20] && i[6]) || (!i[22] && i[11:8] != 4'h0));
    ex = cp && cls && i[6:5] != 2'b00 && !und;
    wbe = ex && (!i[24] || i[21]);
    off = i[22] ? {24'h00_0000, i[11:8], i[3:0]} : o;
    md = i[23] ? b + off : b - off;
    st = {10'h000, i[3:0], i[15:12], i[19:16], i[5], i[6], i[22], i[23], i[24], wbe, i[20],
      und, cp, ex};
    ad = ex ? (i[24] ? md : b) : 32'h0;
    wb = wbe ? md : 32'h0;
    lr = 32'h0;
    if (ex && i[20]) begin
      lr = !i[6] ? {16'h0000, ld[15:0]} : i[5] ? {{16{ld[15]}}, ld[15:0]} :
        {{24{ld[7]}}, ld[7:0]};
    end
  endfunction

  initial begin
    logic [31:0] i, b, o, ld, st, ad, wb, lr;
    logic [3:0] f;
    int k;
    k = $urandom(32'h7e3850f8);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, hsd_pkg::OFF_INSTR, 32'h0);
    chk("instr reset", 32'h0, rd);
    apb(1'b0, hsd_pkg::OFF_STATUS, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped read err", 32'h1, {31'h0, err});
    chk("unmapped read data", 32'h0, rd);
    apb(1'b1, 8'hfc, 32'hffff_ffff);
    chk("unmapped write err", 32'h1, {31'h0, err});
    apb(1'b1, hsd_pkg::OFF_STATUS, 32'hffff_ffff);
    apb(1'b0, hsd_pkg::OFF_STATUS, 32'h0);
    chk("status read-only", 32'h0, rd);
    apb(1'b0, hsd_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reads zero", 32'h0, rd);
    pstrb <= 4'h3;
    apb(1'b1, hsd_pkg::OFF_BASE, 32'h1234_5678);
    pstrb <= 4'hc;
    apb(1'b1, hsd_pkg::OFF_BASE, 32'habcd_ef01);
    pstrb <= 4'hf;
    apb(1'b0, hsd_pkg::OFF_BASE, 32'h0);
    chk("byte strobes", 32'habcd_5678, rd);
    $display("register map test done, mismatches %0d", n_errors);
    for (k = 0; k < 240; k++) begin
      i = $urandom;
      i[31:28] = k[3:0];
      if (k % 8 != 0) begin
        i[27:25] = 3'b000;
        i[7] = 1'b1;
        i[4] = 1'b1;
      end
      if (k % 8 != 1 && !i[20]) i[6] = 1'b0;
      if (k % 8 != 2 && !i[22]) i[11:8] = 4'h0;
      if (!i[24]) i[21] = 1'b0;
      if (k % 16 == 7) i[22] = 1'b1;
      if (k % 16 == 7) {i[11:8], i[3:0]} = 8'hff;
      f = 4'($urandom);
      b = (k % 16 == 5) ? 32'h0 : $urandom;
      o = $urandom;
      mem_addr <= b + o;
      apb(1'b1, hsd_pkg::OFF_INSTR, i);
      apb(1'b1, hsd_pkg::OFF_FLAGS, {28'h000_0000, f});
      apb(1'b1, hsd_pkg::OFF_BASE, b);
      apb(1'b1, hsd_pkg::OFF_OFFREG, o);
      ld = mem_data;
      apb(1'b1, hsd_pkg::OFF_LDRAW, ld);
      apb(1'b1, hsd_pkg::OFF_CTRL, 32'h1);
      expect_dec(i, f, b, o, ld, st, ad, wb, lr);
      apb(1'b0, hsd_pkg::OFF_STATUS, 32'h0);
      chk("status", st, rd);
      apb(1'b0, hsd_pkg::OFF_ADDR, 32'h0);
      chk("address", ad, rd);
      apb(1'b0, hsd_pkg::OFF_WBVAL, 32'h0);
      chk("write-back", wb, rd);
      apb(1'b0, hsd_pkg::OFF_LDRES, 32'h0);
      chk("load result", lr, rd);
    end
    $display("decode test done, mismatches %0d", n_errors);
    give_verdict();
  end
endmodule
`default_nettype wire

// file: hsd_dec_if.sv
// signals between the register front end and the decode core
// assumes: both ends share one clock; the core is purely combinational
`timescale 1ns/1ns
`default_nettype none
interface hsd_dec_if;
  logic [31:0] instr;
  logic [3:0] flags;
  logic [31:0] base_val;
  logic [31:0] offreg_val;
  logic [31:0] load_raw;
  hsd_pkg::hsd_status_t status;
  logic [31:0] xfer_addr;
  logic [31:0] wb_val;
  logic [31:0] load_res;

  modport regs (
    output instr, flags, base_val, offreg_val, load_raw,
    input status, xfer_addr, wb_val, load_res
  );
  modport dec (
    input instr, flags, base_val, offreg_val, load_raw,
    output status, xfer_addr, wb_val, load_res
  );
endinterface
`default_nettype wire

// file: hsd_decode_core.sv
// combinational decode of one halfword/signed transfer instruction
// assumes: operands held stable by the register front end
`timescale 1ns/1ns
`default_nettype none
module hsd_decode_core (
  // operands in, results out
  hsd_dec_if.dec d
);
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v, res;
    n = f[hsd_pkg::FLG_N];
    z = f[hsd_pkg::FLG_Z];
    cy = f[hsd_pkg::FLG_C];
    v = f[hsd_pkg::FLG_V];
    unique case (c[3:1])
      3'h0: res = z;
      3'h1: res = cy;
      3'h2: res = n;
      3'h3: res = v;
      3'h4: res = cy & ~z;
      3'h5: res = (n == v);
      3'h6: res = ~z & (n == v);
      3'h7: res = 1'b1;
    endcase
    // the odd code inverts, except the always code
    if (c[0] && c[3:1] != 3'h7) begin
      res = ~res;
    end
    return res;
  endfunction

  logic [31:0] ins;
  logic [31:0] offs;
  logic [31:0] moved;
  logic in_class;
  logic bad;
  hsd_pkg::hsd_status_t s;

  always_comb begin
    ins = d.instr;
    s.cond_pass = cond_ok(ins[hsd_pkg::COND_LSB +: 4], d.flags);
    in_class = ins[hsd_pkg::CLS_LSB +: 3] == 3'h0 && ins[hsd_pkg::MARK1_BIT]
      && ins[hsd_pkg::MARK0_BIT];
    s.sign = ins[hsd_pkg::SIGN_BIT];
    s.half = ins[hsd_pkg::HALF_BIT];
    s.load = ins[hsd_pkg::LD_BIT];
    s.base_index_field = ins[hsd_pkg::BASE_LSB +: 4];
    s.xfer_field = ins[hsd_pkg::XFER_LSB +: 4];
    s.offset_index_field = ins[hsd_pkg::LO_LSB +: 4];
    s.imm = ins[hsd_pkg::IMM_BIT];
    s.up = ins[hsd_pkg::UP_BIT];
    s.pre = ins[hsd_pkg::PRE_BIT];
    // a signed store has no defined meaning; flag it rather than transfer
    bad = (!s.load && s.sign)
      || (!s.imm && ins[hsd_pkg::HI_LSB +: 4] != 4'h0);
    s.undef = in_class && (s.sign || s.half) && bad;
    // exchange pattern 00 belongs to another class
    s.exec = s.cond_pass && in_class && (s.sign || s.half) && !bad;
    if (s.imm) begin
      offs = {24'h000000, ins[hsd_pkg::HI_LSB +: 4], ins[hsd_pkg::LO_LSB +: 4]};
    end else begin
      offs = d.offreg_val;
    end
    moved = s.up ? d.base_val + offs : d.base_val - offs;
    d.xfer_addr = s.pre ? moved : d.base_val;
    d.wb_val = moved;
    // post-indexed always writes back; bit 21 there is left to software
    s.wb_en = s.exec && (!s.pre || ins[hsd_pkg::WB_BIT]);
    d.status = s;
    if (!s.sign) begin
      d.load_res = {16'h0000, d.load_raw[15:0]};
    end else if (!s.half) begin
      d.load_res = {{24{d.load_raw[7]}}, d.load_raw[7:0]};
    end else begin
      d.load_res = {{16{d.load_raw[15]}}, d.load_raw[15:0]};
    end
  end
endmodule
`default_nettype wire

// file: hsd_mem_model.sv
// far-side memory stand-in: returns a data word for a transfer address
// assumes: purely combinational, answers in the same cycle
`timescale 1ns/1ns
`default_nettype none
module hsd_mem_model (
  // lookup
  input wire logic [31:0] addr,
  output logic [31:0] data
);
  // scrambled pattern so both sign bits toggle across addresses
  assign data = (addr * 32'h9e37_79b1) ^ 32'h5a5a_0f0f;
endmodule
`default_nettype wire

// file: hsd_pkg.sv
// constants, register map and status layout for the halfword/signed transfer decoder
// assumes: apb slave, 32-bit data, one aligned word per register
`default_nettype none
package hsd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_BASE = 8'h08;
  localparam logic [7:0] OFF_OFFREG = 8'h0c;
  localparam logic [7:0] OFF_LDRAW = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_ADDR = 8'h1c;
  localparam logic [7:0] OFF_WBVAL = 8'h20;
  localparam logic [7:0] OFF_LDRES = 8'h24;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam int unsigned CTRL_GO = 0;

  // flags register bit positions
  localparam int unsigned FLG_V = 0;
  localparam int unsigned FLG_C = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_N = 3;

  // instruction field positions
  localparam int unsigned COND_LSB = 28;
  localparam int unsigned CLS_LSB = 25;
  localparam int unsigned PRE_BIT = 24;
  localparam int unsigned UP_BIT = 23;
  localparam int unsigned IMM_BIT = 22;
  localparam int unsigned WB_BIT = 21;
  localparam int unsigned LD_BIT = 20;
  localparam int unsigned BASE_LSB = 16;
  localparam int unsigned XFER_LSB = 12;
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned MARK1_BIT = 7;
  localparam int unsigned SIGN_BIT = 6;
  localparam int unsigned HALF_BIT = 5;
  localparam int unsigned MARK0_BIT = 4;
  localparam int unsigned LO_LSB = 0;

  typedef struct packed {
    logic [3:0] offset_index_field;
    logic [3:0] xfer_field;
    logic [3:0] base_index_field;
    logic half;
    logic sign;
    logic imm;
    logic up;
    logic pre;
    logic wb_en;
    logic load;
    logic undef;
    logic cond_pass;
    logic exec;
  } hsd_status_t;

  localparam int unsigned STATUS_W = $bits(hsd_status_t);
endpackage
`default_nettype wire

// file: hsd_top.sv
// apb front end for the halfword/signed transfer decoder
// assumes: apb master on pclk; operands loaded by software before a decode strobe
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module hsd_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hsd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // apb answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    logic [31:0] instr;
    logic [3:0] flags;
    logic [31:0] base;
    logic [31:0] offreg;
    logic [31:0] ldraw;
    hsd_pkg::hsd_status_t st;
    logic [31:0] addr;
    logic [31:0] wbv;
    logic [31:0] ldres;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hsd_state_t;

  localparam hsd_state_t RST_STATE = '{
    instr: hsd_pkg::RST_WORD,
    flags: hsd_pkg::RST_FLAGS,
    base: hsd_pkg::RST_WORD,
    offreg: hsd_pkg::RST_WORD,
    ldraw: hsd_pkg::RST_WORD,
    st: '0,
    addr: hsd_pkg::RST_WORD,
    wbv: hsd_pkg::RST_WORD,
    ldres: hsd_pkg::RST_WORD,
    prdata: hsd_pkg::RST_WORD,
    pready: 1'b0,
    pslverr: 1'b0
  };

  hsd_state_t r_reg;
  hsd_state_t r_next;
  hsd_dec_if d ();

  hsd_decode_core hsd_decode_core_inst (
    .d(d)
  );

  assign d.instr = r_reg.instr;
  assign d.flags = r_reg.flags;
  assign d.base_val = r_reg.base;
  assign d.offreg_val = r_reg.offreg;
  assign d.load_raw = r_reg.ldraw;

  function automatic logic mapped(input logic [hsd_pkg::ADDR_W-1:0] a);
    return a == hsd_pkg::OFF_INSTR || a == hsd_pkg::OFF_FLAGS
      || a == hsd_pkg::OFF_BASE || a == hsd_pkg::OFF_OFFREG
      || a == hsd_pkg::OFF_LDRAW || a == hsd_pkg::OFF_CTRL
      || a == hsd_pkg::OFF_STATUS || a == hsd_pkg::OFF_ADDR
      || a == hsd_pkg::OFF_WBVAL || a == hsd_pkg::OFF_LDRES;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic setup;
  logic access;
  logic go;

  always_comb begin
    setup = psel && !penable;
    // write takes effect only at the edge where the master sees pready
    access = psel && penable && r_reg.pready && pwrite && mapped(paddr);
    go = access && paddr == hsd_pkg::OFF_CTRL && pstrb[0] && pwdata[hsd_pkg::CTRL_GO];
    r_next = r_reg;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    if (setup) begin
      // answer one cycle after setup: zero wait states
      r_next.pready = 1'b1;
      r_next.pslverr = !mapped(paddr);
      r_next.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          hsd_pkg::OFF_INSTR: r_next.prdata = r_reg.instr;
          hsd_pkg::OFF_FLAGS: r_next.prdata = {28'h0000000, r_reg.flags};
          hsd_pkg::OFF_BASE: r_next.prdata = r_reg.base;
          hsd_pkg::OFF_OFFREG: r_next.prdata = r_reg.offreg;
          hsd_pkg::OFF_LDRAW: r_next.prdata = r_reg.ldraw;
          hsd_pkg::OFF_STATUS: r_next.prdata = {10'h000, r_reg.st};
          hsd_pkg::OFF_ADDR: r_next.prdata = r_reg.addr;
          hsd_pkg::OFF_WBVAL: r_next.prdata = r_reg.wbv;
          hsd_pkg::OFF_LDRES: r_next.prdata = r_reg.ldres;
          default: r_next.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (access) begin
      unique case (paddr)
        hsd_pkg::OFF_INSTR: r_next.instr = merge(r_reg.instr, pwdata, pstrb);
        hsd_pkg::OFF_FLAGS: begin
          if (pstrb[0]) begin
            r_next.flags = pwdata[3:0];
          end
        end
        hsd_pkg::OFF_BASE: r_next.base = merge(r_reg.base, pwdata, pstrb);
        hsd_pkg::OFF_OFFREG: r_next.offreg = merge(r_reg.offreg, pwdata, pstrb);
        hsd_pkg::OFF_LDRAW: r_next.ldraw = merge(r_reg.ldraw, pwdata, pstrb);
        default: r_next.prdata = r_next.prdata;
      endcase
    end
    if (go) begin
      r_next.st = d.status;
      // a suppressed transfer leaves address and write-back at zero
      r_next.addr = d.status.exec ? d.xfer_addr : 32'h0000_0000;
      r_next.wbv = d.status.wb_en ? d.wb_val : 32'h0000_0000;
      r_next.ldres = (d.status.exec && d.status.load) ? d.load_res : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= RST_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> r_reg.pready ##1 !r_reg.pready)
    else $error("pready not a single cycle after setup");

  a_cond_gate: assert property (@(posedge pclk) disable iff (!presetn)
    go && !d.status.cond_pass |=> !r_reg.st.exec && !r_reg.st.wb_en && r_reg.wbv == 32'h0)
    else $error("failed predicate still transferred");

  a_class_bits: assert property (@(posedge pclk) disable iff (!presetn)
    go |=> r_reg.st.exec |-> ($past(r_reg.instr[27:25]) == 3'h0
      && $past(r_reg.instr[7]) && $past(r_reg.instr[4])))
    else $error("transfer outside the instruction class");

  a_swap_excl: assert property (@(posedge pclk) disable iff (!presetn)
    go && r_reg.instr[6:5] == 2'b00 |=> !r_reg.st.exec && !r_reg.st.undef)
    else $error("exchange pattern decoded as transfer");

  a_store_undef: assert property (@(posedge pclk) disable iff (!presetn)
    go && r_reg.instr[27:25] == 3'h0 && r_reg.instr[7] && r_reg.instr[4]
      && !r_reg.instr[20] && r_reg.instr[6] |=> r_reg.st.undef && !r_reg.st.exec)
    else $error("signed store not flagged undefined");

  a_imm_up: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[24:22] == 3'b111
      |=> r_reg.addr == $past(r_reg.base) + {24'h0, $past(r_reg.instr[11:8]),
        $past(r_reg.instr[3:0])})
    else $error("immediate offset address wrong");

  a_reg_down: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[24:22] == 3'b100
      |=> r_reg.addr == $past(r_reg.base) - $past(r_reg.offreg))
    else $error("register offset subtraction wrong");

  a_post_addr: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && !r_reg.instr[24] |=> r_reg.addr == $past(r_reg.base))
    else $error("post-indexed address is not the base");

  a_post_wb: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && !r_reg.instr[24] |=> r_reg.st.wb_en)
    else $error("post-indexed transfer without write-back");

  a_pre_wb: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[24]
      |=> r_reg.st.wb_en == $past(r_reg.instr[21]) && (!r_reg.st.wb_en || r_reg.wbv == r_reg.addr))
    else $error("pre-indexed write-back mismatch");

  a_sext_byte: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[20] && r_reg.instr[6:5] == 2'b10
      |=> r_reg.ldres == {{24{$past(r_reg.ldraw[7])}}, $past(r_reg.ldraw[7:0])})
    else $error("signed byte not extended from bit 7");

  a_sext_half: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[20] && r_reg.instr[6:5] == 2'b11
      |=> r_reg.ldres[31:16] == {16{$past(r_reg.ldraw[15])}})
    else $error("signed half not extended from bit 15");

  // bus handshake checks
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped(paddr)
      |=> r_reg.pready && r_reg.pslverr)
    else $error("unmapped access without slave error");

  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && mapped(paddr)
      |=> r_reg.pready && !r_reg.pslverr)
    else $error("mapped access answered with slave error");

  a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable)
      |=> !r_reg.pready && !r_reg.pslverr)
    else $error("answer without a setup cycle");

  a_read_instr: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == hsd_pkg::OFF_INSTR
      |=> r_reg.prdata == $past(r_reg.instr))
    else $error("instruction read data wrong");

  a_write_full: assert property (@(posedge pclk) disable iff (!presetn)
    access && paddr == hsd_pkg::OFF_OFFREG && pstrb == 4'hf
      |=> r_reg.offreg == $past(pwdata))
    else $error("full word write did not land");

  // decode result checks
  a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !go |=> $stable(r_reg.st) && $stable(r_reg.addr) && $stable(r_reg.wbv)
      && $stable(r_reg.ldres))
    else $error("results changed without a decode strobe");

  a_pred_always: assert property (@(posedge pclk) disable iff (!presetn)
    go && r_reg.instr[31:28] == 4'he
      |=> r_reg.st.cond_pass)
    else $error("always predicate did not pass");

  a_pred_eq: assert property (@(posedge pclk) disable iff (!presetn)
    go && r_reg.instr[31:28] == 4'h0
      |=> r_reg.st.cond_pass == $past(r_reg.flags[hsd_pkg::FLG_Z]))
    else $error("equal predicate does not follow zero flag");

  a_cond_zeroes: assert property (@(posedge pclk) disable iff (!presetn)
    go && !d.status.cond_pass
      |=> r_reg.addr == 32'h0 && r_reg.ldres == 32'h0)
    else $error("failed predicate left address or load result");

  a_class_out: assert property (@(posedge pclk) disable iff (!presetn)
    go && r_reg.instr[27:25] != 3'h0
      |=> !r_reg.st.exec && !r_reg.st.undef)
    else $error("foreign class decoded");

  a_reg_up: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[24:22] == 3'b110
      |=> r_reg.addr == $past(r_reg.base) + $past(r_reg.offreg))
    else $error("register offset addition wrong");

  a_imm_down: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[24:22] == 3'b101
      |=> r_reg.addr == $past(r_reg.base) - {24'h0, $past(r_reg.instr[11:8]), $past(r_reg.instr[3:0])})
    else $error("immediate offset subtraction wrong");

  a_post_reg_wb: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[24:22] == 3'b010
      |=> r_reg.wbv == $past(r_reg.base) + $past(r_reg.offreg))
    else $error("post-indexed write-back value wrong");

  a_pre_no_wb: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[24] && !r_reg.instr[21]
      |=> r_reg.wbv == 32'h0 && !r_reg.st.wb_en)
    else $error("pre-indexed write-back without request");

  a_reg_fields: assert property (@(posedge pclk) disable iff (!presetn)
    go |=> r_reg.st.base_index_field == $past(r_reg.instr[19:16])
      && r_reg.st.xfer_field == $past(r_reg.instr[15:12]))
    else $error("register number fields wrong");

  a_load_dir: assert property (@(posedge pclk) disable iff (!presetn)
    go && !r_reg.instr[20]
      |=> !r_reg.st.load && r_reg.ldres == 32'h0)
    else $error("store produced a load result");

  a_reg_form_undef: assert property (@(posedge pclk) disable iff (!presetn)
    go && r_reg.instr[27:25] == 3'h0 && r_reg.instr[7] && r_reg.instr[4]
      && r_reg.instr[6:5] != 2'b00 && !r_reg.instr[22] && r_reg.instr[11:8] != 4'h0 |=> r_reg.st.undef)
    else $error("register form with nonzero high nibble accepted");

  a_uhalf_zext: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[20] && r_reg.instr[6:5] == 2'b01
      |=> r_reg.ldres == {16'h0000, $past(r_reg.ldraw[15:0])})
    else $error("unsigned half not zero extended");

  a_byte_low: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.exec && r_reg.instr[6:5] == 2'b10
      |=> r_reg.ldres[7:0] == $past(r_reg.ldraw[7:0]))
    else $error("signed byte not in low lane");

  a_undef_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    go && d.status.undef
      |=> !r_reg.st.exec && r_reg.addr == 32'h0 && r_reg.wbv == 32'h0)
    else $error("undefined encoding still transferred");
endmodule
`default_nettype wire
